// ### rtl/sae_defs.svh
`ifndef SAE_DEFS_SVH
`define SAE_DEFS_SVH
// Operation
// - with strap high, load station address from serial ROM words from 0x1 after reset
// - word 0x1 to low, 0x2 to middle, 0x3 to high register
// - software writes change registers only, never the serial ROM contents
// - three 16-bit read/write station address words, low word least significant
// - bus speed code 00 125MHz, 01 62.5MHz, 10 41.66MHz, 11 25MHz
// - without serial ROM the bus speed code resets to zero
// - with serial ROM, config word bit 1 sets speed code 00 or 11
// - bus speed stays software writable after the serial ROM load
// - strap high loads base and station address; strap low gives base 0x300
// - software access bit 4 hands ROM pins to control bits; clear blocks access
// - read-only bit 3 returns the live ROM serial input pin level
// - control bits 2..0 drive serial out, serial clock and chip select pins
// - tx self-test: bit 12 finished, bit 11 failed, read-only
// - rx self-test: bit 4 finished, bit 3 failed, read-only
// - six-bit bank select at offset 0xE in every bank picks the bank
`define SAE_OFS_WORD0 4'h0
`define SAE_OFS_WORD1 4'h2
`define SAE_OFS_WORD2 4'h4
`define SAE_OFS_BANK_SEL 4'he
`define SAE_BANK_BUS 6'h00
`define SAE_BANK_ADDR 6'h02
`define SAE_BANK_CTRL 6'h03
`define SAE_RST_BANK 6'h00
`define SAE_RST_BASE 16'h0300
`define SAE_RST_MAC 16'h0000
`define SAE_RST_PINS 3'h0
`define SAE_BASE_LSB 5
`define SAE_SW_ACC_BIT 4
`define SAE_DI_BIT 3
`define SAE_TXD_BIT 12
`define SAE_TXF_BIT 11
`define SAE_RXD_BIT 4
`define SAE_RXF_BIT 3
`define SAE_EE_BASE_WORD 6'h00
`define SAE_EE_MAC_LO_WORD 6'h01
`define SAE_EE_MAC_MID_WORD 6'h02
`define SAE_EE_MAC_HI_WORD 6'h03
`define SAE_EE_CFG_WORD 6'h06
`define SAE_CFG_SPEED_BIT 1
`define SAE_EE_READ_OP 3'h6
`define SAE_EE_LAST_BIT 5'd25
`define SAE_EE_CMD_BITS 5'd9
`define SAE_EE_LAST_IDX 3'd4
`define SAE_CLK_NS 25
`define SAE_SK_HALF_NS 500
`define SAE_SK_HALF_CYC ((`SAE_SK_HALF_NS + `SAE_CLK_NS - 1) / `SAE_CLK_NS)
`endif

// ### rtl/sae_pkg.sv
package sae_pkg;
   typedef enum {LD_IDLE, LD_RUN, LD_GAP} sae_ld_state_t;
   typedef enum logic [1:0] {
      SPD_125 = 2'h0,
      SPD_62P5 = 2'h1,
      SPD_41P66 = 2'h2,
      SPD_25 = 2'h3
   } sae_speed_t;
endpackage : sae_pkg

// ### rtl/sae_selftest_status.sv
`timescale 1ns/1ps
module sae_selftest_status (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_done_evt,
   input wire logic tx_fail_evt,
   input wire logic rx_done_evt,
   input wire logic rx_fail_evt,
   output logic [3:0] flags
);
   logic [3:0] next_flags;
   // sticky until hardware reset; order tx_done, tx_fail, rx_done, rx_fail
   always_comb begin
      next_flags = flags | {tx_done_evt, tx_fail_evt, rx_done_evt, rx_fail_evt};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= 4'h0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule : sae_selftest_status

// ### rtl/sae_rom_loader.sv
`timescale 1ns/1ps
`include "sae_defs.svh"
module sae_rom_loader #(
   parameter int HALF_CYC = `SAE_SK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic rom_di,
   output logic cs,
   output logic sk,
   output logic dout,
   output logic word_valid,
   output logic [5:0] word_addr,
   output logic [15:0] word_data,
   output logic busy
);
   sae_pkg::sae_ld_state_t st, next_st;
   logic [15:0] div, next_div;
   logic [4:0] bitn, next_bitn;
   logic [2:0] idx, next_idx;
   logic [8:0] cmd, next_cmd;
   logic [15:0] sh, next_sh;
   logic next_cs, next_sk, next_dout, next_valid;
   logic half_end;

   // base, three station words, then the config word
   function automatic logic [5:0] word_of(input logic [2:0] i);
      unique case (i)
         3'd0: word_of = `SAE_EE_BASE_WORD;
         3'd1: word_of = `SAE_EE_MAC_LO_WORD;
         3'd2: word_of = `SAE_EE_MAC_MID_WORD;
         3'd3: word_of = `SAE_EE_MAC_HI_WORD;
         default: word_of = `SAE_EE_CFG_WORD;
      endcase
   endfunction : word_of

   assign word_addr = word_of(idx);
   assign word_data = sh;
   assign busy = (st != sae_pkg::LD_IDLE);
   assign half_end = (div == 16'(HALF_CYC - 1));

   always_comb begin
      next_st = st;
      next_div = half_end ? 16'h0000 : div + 16'h0001;
      next_bitn = bitn;
      next_idx = idx;
      next_cmd = cmd;
      next_sh = sh;
      next_cs = cs;
      next_sk = sk;
      next_dout = dout;
      next_valid = 1'b0;
      unique case (st)
         sae_pkg::LD_IDLE: begin
            next_div = 16'h0000;
            if (start) begin
               next_st = sae_pkg::LD_RUN;
               next_idx = 3'd0;
               next_bitn = 5'd0;
               next_cmd = {`SAE_EE_READ_OP, word_of(3'd0)};
               next_cs = 1'b1;
               next_dout = 1'b1;
            end
         end
         sae_pkg::LD_RUN: if (half_end) begin
            next_sk = ~sk;
            if (!sk) begin
               // rom output sampled on the rising serial clock
               next_sh = {sh[14:0], rom_di};
            end else if (bitn == `SAE_EE_LAST_BIT) begin
               next_valid = 1'b1;
               next_st = sae_pkg::LD_GAP;
               next_cs = 1'b0;
               next_dout = 1'b0;
            end else begin
               next_bitn = bitn + 5'd1;
               next_cmd = {cmd[7:0], 1'b0};
               next_dout = (next_bitn < `SAE_EE_CMD_BITS) ? cmd[7] : 1'b0;
            end
         end
         sae_pkg::LD_GAP: if (half_end) begin
            if (idx == `SAE_EE_LAST_IDX) begin
               next_st = sae_pkg::LD_IDLE;
            end else begin
               next_st = sae_pkg::LD_RUN;
               next_idx = idx + 3'd1;
               next_bitn = 5'd0;
               next_cmd = {`SAE_EE_READ_OP, word_of(idx + 3'd1)};
               next_cs = 1'b1;
               next_dout = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= sae_pkg::LD_IDLE;
         div <= 16'h0000;
         bitn <= 5'd0;
         idx <= 3'd0;
         cmd <= 9'h000;
         sh <= 16'h0000;
         cs <= 1'b0;
         sk <= 1'b0;
         dout <= 1'b0;
         word_valid <= 1'b0;
      end else begin
         st <= next_st;
         div <= next_div;
         bitn <= next_bitn;
         idx <= next_idx;
         cmd <= next_cmd;
         sh <= next_sh;
         cs <= next_cs;
         sk <= next_sk;
         dout <= next_dout;
         word_valid <= next_valid;
      end
   end
endmodule : sae_rom_loader

// ### rtl/sae_regs.sv
`timescale 1ns/1ps
`include "sae_defs.svh"
module sae_regs #(
   parameter int SK_HALF_CYC = `SAE_SK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_cs,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_offset,
   input wire logic [1:0] host_be,
   input wire logic [15:0] host_wdata,
   output logic [15:0] host_rdata,
   input wire logic rom_enable_strap,
   input wire logic rom_serial_in_pin,
   output logic rom_serial_out_pin,
   output logic rom_serial_clock_pin,
   output logic rom_chip_select_pin,
   input wire logic tx_selftest_done_evt,
   input wire logic tx_selftest_fail_evt,
   input wire logic rx_selftest_done_evt,
   input wire logic rx_selftest_fail_evt,
   output logic [1:0] bus_speed_select,
   output logic [15:0] base_address,
   output logic [47:0] station_address,
   output logic rom_load_busy
);
   logic [5:0] bank_select_field, next_bank;
   logic [15:0] station_address_low, next_mac_lo;
   logic [15:0] station_address_middle, next_mac_mid;
   logic [15:0] station_address_high, next_mac_hi;
   logic [10:0] base_hi, next_base_hi;
   logic [1:0] speed, next_speed;
   logic rom_software_access_en, next_sw_acc;
   logic [2:0] rom_pin_bits, next_pin_bits;
   logic [15:0] next_rdata;
   logic next_so, next_sck, next_csel;
   logic boot_pending, next_boot;
   logic ld_start, next_ld_start;
   logic next_busy;
   logic [3:0] st_flags;
   logic ld_cs, ld_sk, ld_do, ld_valid, ld_busy;
   logic [5:0] ld_addr;
   logic [15:0] ld_data;
   logic wr_en, rd_en;
   logic [3:0] wofs;
   logic [15:0] speed_word, pin_word, bist_word;
   logic [15:0] base_merged;

   sae_rom_loader #(
      .HALF_CYC(SK_HALF_CYC)
   ) u_loader (
      .clk(clk),
      .rst_n(rst_n),
      .start(ld_start),
      .rom_di(rom_serial_in_pin),
      .cs(ld_cs),
      .sk(ld_sk),
      .dout(ld_do),
      .word_valid(ld_valid),
      .word_addr(ld_addr),
      .word_data(ld_data),
      .busy(ld_busy)
   );

   sae_selftest_status u_selftest (
      .clk(clk),
      .rst_n(rst_n),
      .tx_done_evt(tx_selftest_done_evt),
      .tx_fail_evt(tx_selftest_fail_evt),
      .rx_done_evt(rx_selftest_done_evt),
      .rx_fail_evt(rx_selftest_fail_evt),
      .flags(st_flags)
   );

   // byte-lane merge of a host write into a word
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [1:0] be
   );
      merge = old;
      if (be[0]) begin
         merge[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge[15:8] = wd[15:8];
      end
   endfunction : merge

   assign wr_en = host_cs & host_wr;
   assign rd_en = host_cs & host_rd;
   // odd byte offsets reach the same word
   assign wofs = {host_offset[3:1], 1'b0};
   assign base_merged = merge(base_address, host_wdata, host_be);

   // read images; reserved bits are zero
   assign speed_word = {14'h0000, speed};
   assign pin_word = {11'h000, rom_software_access_en, rom_serial_in_pin,
                      rom_pin_bits};
   always_comb begin
      bist_word = 16'h0000;
      bist_word[`SAE_TXD_BIT] = st_flags[3];
      bist_word[`SAE_TXF_BIT] = st_flags[2];
      bist_word[`SAE_RXD_BIT] = st_flags[1];
      bist_word[`SAE_RXF_BIT] = st_flags[0];
   end

   // strap sampled once, on the first edge after reset release
   always_comb begin
      next_boot = 1'b0;
      next_ld_start = boot_pending & rom_enable_strap;
   end

   // host register writes
   always_comb begin
      next_bank = bank_select_field;
      next_mac_lo = station_address_low;
      next_mac_mid = station_address_middle;
      next_mac_hi = station_address_high;
      next_base_hi = base_hi;
      next_speed = speed;
      next_sw_acc = rom_software_access_en;
      next_pin_bits = rom_pin_bits;
      if (wr_en) begin
         if (wofs == `SAE_OFS_BANK_SEL) begin
            // reachable from every bank
            if (host_be[0]) begin
               next_bank = host_wdata[5:0];
            end
         end else begin
            unique case (bank_select_field)
               `SAE_BANK_BUS: begin
                  if (wofs == `SAE_OFS_WORD0) begin
                     next_base_hi = base_merged[15:`SAE_BASE_LSB];
                  end
               end
               `SAE_BANK_ADDR: begin
                  // register only, nothing is sent to the rom
                  unique case (wofs)
                     `SAE_OFS_WORD0: next_mac_lo = merge(station_address_low,
                                                         host_wdata, host_be);
                     `SAE_OFS_WORD1: next_mac_mid = merge(station_address_middle,
                                                          host_wdata, host_be);
                     `SAE_OFS_WORD2: next_mac_hi = merge(station_address_high,
                                                         host_wdata, host_be);
                     default: ;
                  endcase
               end
               `SAE_BANK_CTRL: begin
                  unique case (wofs)
                     `SAE_OFS_WORD0: begin
                        // writable at any time, also after the load
                        if (host_be[0]) begin
                           next_speed = host_wdata[1:0];
                        end
                     end
                     `SAE_OFS_WORD1: begin
                        if (host_be[0]) begin
                           next_sw_acc = host_wdata[`SAE_SW_ACC_BIT];
                           next_pin_bits = host_wdata[2:0];
                        end
                     end
                     // self-test word is read-only
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
      end
      // rom words overwrite a host write of the same cycle
      if (ld_valid) begin
         unique case (ld_addr)
            `SAE_EE_BASE_WORD: next_base_hi = ld_data[15:`SAE_BASE_LSB];
            `SAE_EE_MAC_LO_WORD: next_mac_lo = ld_data;
            `SAE_EE_MAC_MID_WORD: next_mac_mid = ld_data;
            `SAE_EE_MAC_HI_WORD: next_mac_hi = ld_data;
            `SAE_EE_CFG_WORD: begin
               next_speed = ld_data[`SAE_CFG_SPEED_BIT] ? sae_pkg::SPD_25
                                                        : sae_pkg::SPD_125;
            end
            default: ;
         endcase
      end
   end

   // host read data, taken one edge after the strobe
   always_comb begin
      next_rdata = host_rdata;
      if (rd_en) begin
         next_rdata = 16'h0000;
         if (wofs == `SAE_OFS_BANK_SEL) begin
            next_rdata = {10'h000, bank_select_field};
         end else begin
            unique case (bank_select_field)
               `SAE_BANK_BUS: begin
                  if (wofs == `SAE_OFS_WORD0) begin
                     next_rdata = base_address;
                  end
               end
               `SAE_BANK_ADDR: begin
                  unique case (wofs)
                     `SAE_OFS_WORD0: next_rdata = station_address_low;
                     `SAE_OFS_WORD1: next_rdata = station_address_middle;
                     `SAE_OFS_WORD2: next_rdata = station_address_high;
                     default: ;
                  endcase
               end
               `SAE_BANK_CTRL: begin
                  unique case (wofs)
                     `SAE_OFS_WORD0: next_rdata = speed_word;
                     `SAE_OFS_WORD1: next_rdata = pin_word;
                     `SAE_OFS_WORD2: next_rdata = bist_word;
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
      end
   end

   // pin ownership: loader, then software, else parked low
   always_comb begin
      next_busy = ld_busy;
      if (ld_busy) begin
         next_so = ld_do;
         next_sck = ld_sk;
         next_csel = ld_cs;
      end else if (rom_software_access_en) begin
         // timing is entirely the host's
         next_so = rom_pin_bits[2];
         next_sck = rom_pin_bits[1];
         next_csel = rom_pin_bits[0];
      end else begin
         next_so = 1'b0;
         next_sck = 1'b0;
         next_csel = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_select_field <= `SAE_RST_BANK;
         station_address_low <= `SAE_RST_MAC;
         station_address_middle <= `SAE_RST_MAC;
         station_address_high <= `SAE_RST_MAC;
         base_hi <= 11'(`SAE_RST_BASE >> `SAE_BASE_LSB);
         speed <= sae_pkg::SPD_125;
         rom_software_access_en <= 1'b0;
         rom_pin_bits <= `SAE_RST_PINS;
         host_rdata <= 16'h0000;
         boot_pending <= 1'b1;
         ld_start <= 1'b0;
         rom_load_busy <= 1'b0;
      end else begin
         bank_select_field <= next_bank;
         station_address_low <= next_mac_lo;
         station_address_middle <= next_mac_mid;
         station_address_high <= next_mac_hi;
         base_hi <= next_base_hi;
         speed <= next_speed;
         rom_software_access_en <= next_sw_acc;
         rom_pin_bits <= next_pin_bits;
         host_rdata <= next_rdata;
         boot_pending <= next_boot;
         ld_start <= next_ld_start;
         // start pulse covers the edge before the loader leaves idle
         rom_load_busy <= next_busy | next_ld_start | ld_start;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_serial_out_pin <= 1'b0;
         rom_serial_clock_pin <= 1'b0;
         rom_chip_select_pin <= 1'b0;
         bus_speed_select <= sae_pkg::SPD_125;
         base_address <= `SAE_RST_BASE;
         station_address <= {`SAE_RST_MAC, `SAE_RST_MAC, `SAE_RST_MAC};
      end else begin
         rom_serial_out_pin <= next_so;
         rom_serial_clock_pin <= next_sck;
         rom_chip_select_pin <= next_csel;
         bus_speed_select <= next_speed;
         base_address <= {next_base_hi, 5'h00};
         station_address <= {next_mac_hi, next_mac_mid, next_mac_lo};
      end
   end
endmodule : sae_regs

// ### tb/sae_regs_chk.sv
`timescale 1ns/1ps
module sae_regs_chk #(
   parameter int SK_HALF_CYC = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_cs,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_offset,
   input wire logic [15:0] host_rdata,
   input wire logic rom_enable_strap,
   input wire logic rom_serial_out_pin,
   input wire logic rom_serial_clock_pin,
   input wire logic rom_chip_select_pin,
   input wire logic [1:0] bus_speed_select,
   input wire logic [15:0] base_address,
   input wire logic [47:0] station_address,
   input wire logic rom_load_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] pin_vec;
   logic sk_q;
   int sk_run;
   assign pin_vec = {rom_serial_out_pin, rom_serial_clock_pin, rom_chip_select_pin};
   // cycles the serial clock pin has held its level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sk_q <= 1'b0;
         sk_run <= 0;
      end else begin
         sk_q <= rom_serial_clock_pin;
         sk_run <= (rom_serial_clock_pin != sk_q) ? 0 : sk_run + 1;
      end
   end
   property p_rst_vals;
      $rose(rst_n) |-> bus_speed_select == 2'h0 && station_address == 48'h0
         && host_rdata == 16'h0 && pin_vec == 3'h0;
   endproperty
   property p_rdata_hold;
      !(host_cs && host_rd) |=> $stable(host_rdata);
   endproperty
   property p_bank_rsv;
      host_cs && host_rd && host_offset[3:1] == 3'h7 |=> host_rdata[15:6] == 10'h0;
   endproperty
   property p_busy_start;
      $rose(rst_n) && rom_enable_strap |-> ##[1:3] rom_load_busy;
   endproperty
   property p_no_load;
      !rom_enable_strap |-> !rom_load_busy;
   endproperty
   property p_cs_dout;
      rom_load_busy && $rose(rom_chip_select_pin) |-> rom_serial_out_pin;
   endproperty
   property p_sk_half;
      rom_load_busy && rom_serial_clock_pin != sk_q |-> sk_run >= SK_HALF_CYC - 1;
   endproperty
   property p_speed_cause;
      $changed(bus_speed_select) |-> $past(host_cs && host_wr) || $past(rom_load_busy);
   endproperty
   property p_mac_cause;
      $changed(station_address) |-> $past(host_cs && host_wr) || $past(rom_load_busy);
   endproperty
   property p_pin_cause;
      $changed(pin_vec) |-> $past(host_cs && host_wr, 2) || $past(rom_load_busy, 2)
         || $past(rom_load_busy);
   endproperty
   property p_base_low;
      $changed(base_address) |-> base_address[4:0] == 5'h0
         && ($past(host_cs && host_wr) || $past(rom_load_busy));
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_bank_rsv: assert property (p_bank_rsv) else $error("bank high bits set");
   a_busy_start: assert property (p_busy_start) else $error("no load start");
   a_no_load: assert property (p_no_load) else $error("load without strap");
   a_cs_dout: assert property (p_cs_dout) else $error("bad first bit");
   a_sk_half: assert property (p_sk_half) else $error("clock half short");
   a_speed_cause: assert property (p_speed_cause) else $error("speed moved");
   a_mac_cause: assert property (p_mac_cause) else $error("address moved");
   a_pin_cause: assert property (p_pin_cause) else $error("pins moved");
   a_base_low: assert property (p_base_low) else $error("base low bits set");
   c_load_done: cover property ($fell(rom_load_busy));
   c_bank_read: cover property (host_cs && host_rd && host_offset == 4'he);
   c_sw_pins: cover property (!rom_load_busy && rom_chip_select_pin && rom_serial_clock_pin);
endmodule : sae_regs_chk

bind sae_regs sae_regs_chk #(.SK_HALF_CYC(SK_HALF_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
   .host_offset(host_offset), .host_rdata(host_rdata), .rom_enable_strap(rom_enable_strap),
   .rom_serial_out_pin(rom_serial_out_pin), .rom_serial_clock_pin(rom_serial_clock_pin),
   .rom_chip_select_pin(rom_chip_select_pin), .bus_speed_select(bus_speed_select),
   .base_address(base_address), .station_address(station_address),
   .rom_load_busy(rom_load_busy)
);

// ### tb/sae_rom_model.sv
`timescale 1ns/1ps
module sae_rom_model (
   input wire logic cs,
   input wire logic sk,
   input wire logic din,
   output logic dout
);
   logic [15:0] mem [64];
   logic [8:0] cmd;
   logic [15:0] sh;
   logic q;
   int cnt;
   int bad_cmds;
   initial begin
      cnt = 0;
      bad_cmds = 0;
      q = 1'b0;
      cmd = 9'h000;
      sh = 16'h0000;
   end
   always @(posedge cs) cnt = 0;
   always @(posedge sk) begin
      if (cs) begin
         if (cnt < 9) cmd = {cmd[7:0], din};
         cnt = cnt + 1;
         // anything but a read would alter stored words
         if (cnt == 9 && cmd[8:6] !== 3'b110) bad_cmds = bad_cmds + 1;
      end
   end
   // data moves on the falling clock, steady at the next rise
   always @(negedge sk) begin
      if (cs && cnt == 9) begin
         q = 1'b0;
         sh = mem[cmd[5:0]];
      end else if (cs && cnt > 9 && cnt < 26) begin
         q = sh[15];
         sh = {sh[14:0], 1'b0};
      end
   end
   // deselected line shows the inverse of its last level
   assign dout = cs ? q : ~q;
endmodule : sae_rom_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] ST_BIT [4] = '{16'h1000, 16'h0800, 16'h0010, 16'h0008};
   logic clk, rst_n, host_cs, host_wr, host_rd, strap, rom_di, so, sclk, scs, busy, b;
   logic [3:0] host_offset, evt;
   logic [1:0] host_be, speed, be_r;
   logic [15:0] host_wdata, host_rdata, base, rd, w, got, st;
   logic [47:0] mac_out, mac;
   logic [8:0] cmd;
   logic [5:0] a;
   int n_errors, n_tests, cyc;
   sae_regs #(.SK_HALF_CYC(2)) dut (
      .clk(clk), .rst_n(rst_n), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
      .host_offset(host_offset), .host_be(host_be), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .rom_enable_strap(strap), .rom_serial_in_pin(rom_di),
      .rom_serial_out_pin(so), .rom_serial_clock_pin(sclk), .rom_chip_select_pin(scs),
      .tx_selftest_done_evt(evt[0]), .tx_selftest_fail_evt(evt[1]),
      .rx_selftest_done_evt(evt[2]), .rx_selftest_fail_evt(evt[3]),
      .bus_speed_select(speed), .base_address(base), .station_address(mac_out),
      .rom_load_busy(busy)
   );
   sae_rom_model u_rom (.cs(scs), .sk(sclk), .din(so), .dout(rom_di));
   function automatic logic [15:0] be_merge(input logic [15:0] o, d, input logic [1:0] e);
      return {e[1] ? d[15:8] : o[15:8], e[0] ? d[7:0] : o[7:0]};
   endfunction : be_merge
   function automatic logic [1:0] cfg_speed(input logic [15:0] cfg);
      return cfg[1] ? 2'b11 : 2'b00;
   endfunction : cfg_speed
   task automatic tally_and_finish;
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [47:0] exp, got_v);
      n_tests++;
      if (got_v !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got_v);
      end
   endtask : chk
   task automatic wr(input logic [3:0] ofs, input logic [15:0] d, input logic [1:0] e);
      @(posedge clk);
      host_cs <= 1'b1;
      host_wr <= 1'b1;
      host_offset <= ofs;
      host_wdata <= d;
      host_be <= e;
      @(posedge clk);
      host_cs <= 1'b0;
      host_wr <= 1'b0;
   endtask : wr
   task automatic rdw(input logic [3:0] ofs, output logic [15:0] d);
      @(posedge clk);
      host_cs <= 1'b1;
      host_rd <= 1'b1;
      host_offset <= ofs;
      @(posedge clk);
      host_cs <= 1'b0;
      host_rd <= 1'b0;
      #1 d = host_rdata;
   endtask : rdw
   task automatic pins(input logic [2:0] p);
      wr(4'h2, {11'h0, 1'b1, 1'b0, p}, 2'b11);
      @(posedge clk);
      #1 chk("pins", 48'(p), 48'({so, sclk, scs}));
   endtask : pins
   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 10000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      {rst_n, host_cs, host_wr, host_rd, strap, host_offset, evt, host_be} = '0;
      host_wdata = 16'h0;
      {n_errors, n_tests, cyc} = '0;
      w = 16'($urandom(32'h600f));
      do_reset(1'b0);
      repeat (3) @(posedge clk);
      chk("speed nostrap", 48'h0, 48'(speed));
      chk("base nostrap", 48'h300, 48'(base));
      rdw(4'h0, rd);
      chk("base reg", 48'h300, 48'(rd));
      wr(4'h0, w, 2'b11);
      rdw(4'h0, rd);
      chk("base write", 48'({w[15:5], 5'h00}), 48'(rd));
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 64; k++) u_rom.mem[k] = 16'($urandom);
         u_rom.mem[6][1] = r[0];
         do_reset(1'b1);
         repeat (4) @(posedge clk);
         for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge clk);
         #1 chk("mac load", {u_rom.mem[3], u_rom.mem[2], u_rom.mem[1]}, mac_out);
         chk("base load", 48'({u_rom.mem[0][15:5], 5'h0}), 48'(base));
         chk("speed load", 48'(cfg_speed(u_rom.mem[6])), 48'(speed));
      end
      wr(4'he, 16'hffff, 2'b11);
      rdw(4'he, rd);
      chk("bank", 48'h3f, 48'(rd));
      rdw(4'h0, rd);
      chk("unmapped", 48'h0, 48'(rd));
      wr(4'he, 16'h0002, 2'b01);
      mac = {u_rom.mem[3], u_rom.mem[2], u_rom.mem[1]};
      for (int k = 0; k < 12; k++) begin
         a = 6'($urandom_range(0, 2));
         w = 16'($urandom);
         be_r = 2'($urandom);
         mac[a*16 +: 16] = be_merge(mac[a*16 +: 16], w, be_r);
         wr({a[2:0], 1'b0}, w, be_r);
         rdw({a[2:0], 1'b0}, rd);
         chk("mac word", 48'(mac[a*16 +: 16]), 48'(rd));
      end
      chk("mac out", mac, mac_out);
      chk("rom writes", 48'h0, 48'(u_rom.bad_cmds));
      wr(4'he, 16'h0003, 2'b11);
      for (int k = 0; k < 4; k++) begin
         wr(4'h0, {14'($urandom), 2'(k)}, 2'b11);
         rdw(4'h0, rd);
         chk("speed reg", 48'(k), 48'(rd));
         chk("speed out", 48'(k), 48'(speed));
      end
      st = 16'h0;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         evt <= 4'h1 << k;
         @(posedge clk);
         evt <= 4'h0;
         st = st | ST_BIT[k];
         wr(4'h4, 16'hffff, 2'b11);
         rdw(4'h4, rd);
         chk("selftest", 48'(st), 48'(rd));
      end
      wr(4'h2, 16'h0007, 2'b11);
      repeat (2) @(posedge clk);
      #1 chk("pins blocked", 48'h0, 48'({so, sclk, scs}));
      a = 6'($urandom);
      cmd = {3'b110, a};
      got = 16'h0;
      for (int i = 0; i < 26; i++) begin
         b = (i < 9) ? cmd[8 - i] : 1'b0;
         pins({b, 1'b0, 1'b1});
         pins({b, 1'b1, 1'b1});
         if (i >= 10) begin
            rdw(4'h2, rd);
            got = {got[14:0], rd[3]};
         end
      end
      pins(3'b000);
      chk("sw read", 48'(u_rom.mem[a]), 48'(got));
      tally_and_finish();
   end
endmodule : tb
